/* File: logic/pio_pkg.sv */
// package: constants and types shared by the parallel i/o port design
package pio_pkg;
  // ----------------------------------------
  // widths and counts
  // ----------------------------------------
  localparam int DATA_W = 8; // byte-wide cable
  localparam int N_IN = 5; // input interfaces
  localparam int N_OUT = 6; // output-select lines
  localparam int ADDR_W = 5; // device address bits
  localparam int VEC_W = 3; // one of eight locations
  localparam int FIFO_DEPTH = 4; // words buffered toward the processor
  // ----------------------------------------
  // address map of the decoder
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] IN_BASE = 5'h00; // input devices 0..4
  localparam logic [ADDR_W-1:0] OUT_BASE = 5'h08; // output devices from 8
  // ----------------------------------------
  // timing (strobe minimum width)
  // ----------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int STROBE_MIN_NS = 50;
  localparam int STROBE_MIN_CYC = (STROBE_MIN_NS * CLK_MHZ + 999) / 1000;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
  localparam logic [VEC_W-1:0] VEC_RST = 3'h0;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {IO_IDLE, IO_READ, IO_WRITE} io_op_t;
endpackage

/* File: logic/stream_if.sv */
// interface: valid/ready byte stream between core and fifo
interface stream_if #(parameter int W = 8) ();
  logic valid; // word offered
  logic ready; // word can be taken
  logic [W-1:0] data; // payload
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: logic/pio_fifo.sv */
// module: small synchronous fifo with valid/ready on both sides
module pio_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  stream_if.snk wr,
  stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  // pointer wrap bit only works for power-of-two depths
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("depth must be a power of two, at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH]; // storage
  logic [AW:0] wptr; // write pointer with wrap bit
  logic [AW:0] rptr; // read pointer with wrap bit
  wire push = wr.valid && wr.ready;
  wire pop = rd.valid && rd.ready;
  wire full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  wire empty = wptr == rptr;
  assign wr.ready = !full; // back-pressure to the source
  assign rd.valid = !empty;
  assign rd.data = mem[rptr[AW-1:0]];
  // storage write, no reset needed on data
  always_ff @(posedge sys_clk) begin
    if (push) mem[wptr[AW-1:0]] <= wr.data;
  end
  // pointer update
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) wptr <= wptr + 1'b1;
      if (pop) rptr <= rptr + 1'b1;
    end
  end
endmodule // pio_fifo

/* File: logic/pio_ports.sv */
// module: parallel input and output handshake ports with decoder and arbiter
module pio_ports
  import pio_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  // processor side
  input wire pio_pkg::io_op_t io_op, // idle, read, write cycle
  input wire logic [pio_pkg::ADDR_W-1:0] io_addr, // device address
  input wire logic [pio_pkg::DATA_W-1:0] io_wdata, // byte to an output
  input wire logic io_rready, // processor takes read word
  output logic io_rvalid, // read word available
  output logic [pio_pkg::DATA_W-1:0] io_rdata, // read byte
  output logic irq_n, // inverted request to processor
  output logic [pio_pkg::VEC_W-1:0] irq_vector, // location code
  // input cable side
  input wire logic [pio_pkg::N_IN*pio_pkg::DATA_W-1:0] in_data, // bytes from devices
  input wire logic [pio_pkg::N_IN-1:0] in_ready, // devices' ready strobes
  // output cable side
  output logic [pio_pkg::N_OUT*pio_pkg::DATA_W-1:0] out_data, // buffered bytes
  output logic [pio_pkg::N_OUT-1:0] out_ready, // ready lines to devices
  input wire logic [pio_pkg::N_OUT-1:0] out_accepted // devices' accepted strobes
);
  import pio_pkg::*;
  // ----------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------
  logic [N_IN-1:0] in_rdy_s1, in_rdy_s2, in_rdy_d; // ready sync chain
  logic [N_OUT-1:0] acc_s1, acc_s2, acc_d; // accepted sync chain
  logic [N_IN*DATA_W-1:0] in_dat_s1, in_dat_s2; // data sync chain
  // rising edges only look at the second stage and its delay
  wire [N_IN-1:0] in_rise = in_rdy_s2 & ~in_rdy_d;
  wire [N_OUT-1:0] acc_rise = acc_s2 & ~acc_d;
  // sync processes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_rdy_s1 <= '0;
      in_rdy_s2 <= '0;
      in_rdy_d <= '0;
      acc_s1 <= '0;
      acc_s2 <= '0;
      acc_d <= '0;
    end else begin
      in_rdy_s1 <= in_ready;
      in_rdy_s2 <= in_rdy_s1;
      in_rdy_d <= in_rdy_s2;
      acc_s1 <= out_accepted;
      acc_s2 <= acc_s1;
      acc_d <= acc_s2;
    end
  end
  // data path synchroniser; data is stable before ready so no skew hazard
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_dat_s1 <= '0;
      in_dat_s2 <= '0;
    end else begin
      in_dat_s1 <= in_data;
      in_dat_s2 <= in_dat_s1;
    end
  end
  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // active-low selects, as the decoder drives them; inverted before use
  wire [ADDR_W-1:0] out_off = io_addr - OUT_BASE;
  wire [ADDR_W-1:0] in_off = io_addr - IN_BASE;
  wire in_range = (io_addr >= IN_BASE) && (in_off < ADDR_W'(N_IN));
  wire out_range = (io_addr >= OUT_BASE) && (out_off < ADDR_W'(N_OUT));
  wire [N_OUT-1:0] sel_out_n;
  wire [N_IN-1:0] sel_in_n;
  wire [N_OUT-1:0] sel_out = ~sel_out_n;
  wire [N_IN-1:0] sel_in = ~sel_in_n;
  wire read_go; // read accepted this cycle
  logic [N_OUT-1:0] strobe_d; // last cycle's write strobe
  // ----------------------------------------
  // read path into fifo
  // ----------------------------------------
  stream_if #(.W(DATA_W)) to_fifo ();
  stream_if #(.W(DATA_W)) from_fifo ();
  // read is held off while the fifo is full; op must persist
  assign read_go = (io_op == IO_READ) && in_range && to_fifo.ready;
  logic [N_IN-1:0] req; // interrupt request flags
  genvar g;
  generate
    for (g = 0; g < N_IN; g++) begin : g_in
      assign sel_in_n[g] = !(read_go && in_off == ADDR_W'(g));
      // set beats clear in the same cycle so no event is lost
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) req[g] <= 1'b0;
        else if (in_rise[g]) req[g] <= 1'b1;
        else if (sel_in[g]) req[g] <= 1'b0;
      end
      // checked on every input slot, since a device may sit on any of them
      property p_req_set;
        @(posedge sys_clk) disable iff (!arst_n) in_rise[g] |=> req[g];
      endproperty
      a_req_set: assert property (p_req_set) else $error("request not set by ready rise");
      property p_req_clr;
        @(posedge sys_clk) disable iff (!arst_n) sel_in[g] && !in_rise[g] |=> !req[g];
      endproperty
      a_req_clr: assert property (p_req_clr) else $error("request not cleared by read");
    end
    for (g = 0; g < N_OUT; g++) begin : g_out
      assign sel_out_n[g] = !((io_op == IO_WRITE) && out_range && out_off == ADDR_W'(g));
      // buffer loads only on a strobe, so it stays put while ready is up
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) out_data[g*DATA_W +: DATA_W] <= BYTE_RST;
        else if (sel_out[g]) out_data[g*DATA_W +: DATA_W] <= io_wdata;
      end
      // ready raised at trailing edge; accept clears unless a new trailing edge
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) out_ready[g] <= 1'b0;
        else if (strobe_d[g] && !sel_out[g]) out_ready[g] <= 1'b1;
        else if (acc_rise[g]) out_ready[g] <= 1'b0;
      end
    end
  endgenerate
  // strobe history for trailing edge detection
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) strobe_d <= '0;
    else strobe_d <= sel_out;
  end
  // gather the addressed byte whether or not its flag is set
  logic [DATA_W-1:0] rd_byte;
  always_comb begin
    rd_byte = BYTE_RST;
    for (int i = 0; i < N_IN; i++) begin
      if (sel_in[i]) rd_byte = in_dat_s2[i*DATA_W +: DATA_W];
    end
  end
  assign to_fifo.valid = read_go;
  assign to_fifo.data = rd_byte;
  pio_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wr(to_fifo),
    .rd(from_fifo)
  );
  // registered read output stage
  assign from_fifo.ready = !io_rvalid || io_rready;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      io_rvalid <= 1'b0;
      io_rdata <= BYTE_RST;
    end else if (from_fifo.ready) begin
      io_rvalid <= from_fifo.valid;
      if (from_fifo.valid) io_rdata <= from_fifo.data;
    end
  end
  // ----------------------------------------
  // priority arbiter
  // ----------------------------------------
  // lowest index wins; position fixes priority
  logic [VEC_W-1:0] next_vec;
  always_comb begin
    next_vec = VEC_RST;
    for (int i = N_IN - 1; i >= 0; i--) begin
      if (req[i]) next_vec = VEC_W'(i);
    end
  end
  // request leaves inverted, code follows the winner
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_n <= 1'b1;
      irq_vector <= VEC_RST;
    end else begin
      irq_n <= ~(|req);
      irq_vector <= next_vec;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // the read byte must not move while the processor stalls
  property p_rhold;
    @(posedge sys_clk) disable iff (!arst_n) io_rvalid && !io_rready |=> io_rvalid && $stable(io_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read byte dropped while stalled");
  property p_irq;
    @(posedge sys_clk) disable iff (!arst_n) req[1] && !req[0] |=> !irq_n && irq_vector == 3'h1;
  endproperty
  a_irq: assert property (p_irq) else $error("wrong vector or request");
  property p_onehot;
    @(posedge sys_clk) disable iff (!arst_n) $onehot0(sel_out);
  endproperty
  a_onehot: assert property (p_onehot) else $error("more than one output select");
  property p_load;
    @(posedge sys_clk) disable iff (!arst_n) sel_out[2] |=> out_data[2*DATA_W +: DATA_W] == $past(io_wdata);
  endproperty
  a_load: assert property (p_load) else $error("buffer not loaded");
  property p_trail;
    @(posedge sys_clk) disable iff (!arst_n) $rose(sel_out[0]) |=> !$rose(out_ready[0]);
  endproperty
  a_trail: assert property (p_trail) else $error("ready rose at leading edge");
  property p_acc;
    @(posedge sys_clk) disable iff (!arst_n) acc_rise[0] && !(strobe_d[0] && !sel_out[0]) |=> !out_ready[0];
  endproperty
  a_acc: assert property (p_acc) else $error("ready not cleared by accept");
  property p_hold;
    @(posedge sys_clk) disable iff (!arst_n) out_ready[3] && !sel_out[3] |=> $stable(out_data[3*DATA_W +: DATA_W]);
  endproperty
  a_hold: assert property (p_hold) else $error("output byte changed while ready");
  property p_read;
    @(posedge sys_clk) disable iff (!arst_n)
      read_go && sel_in[2] && !req[2] |-> to_fifo.data == in_dat_s2[2*DATA_W +: DATA_W];
  endproperty
  a_read: assert property (p_read) else $error("flagless read not taken");
endmodule // pio_ports

/* File: tb/pio_device_model.sv */
// partner: peripheral devices on the input and output cables
module pio_device_model
  import pio_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [pio_pkg::N_OUT*pio_pkg::DATA_W-1:0] out_data,
  input wire logic [pio_pkg::N_OUT-1:0] out_ready,
  output logic [pio_pkg::N_IN*pio_pkg::DATA_W-1:0] in_data,
  output logic [pio_pkg::N_IN-1:0] in_ready,
  output logic [pio_pkg::N_OUT-1:0] out_accepted
);
  timeunit 1ns;
  timeprecision 1ns;
  int accept_delay = 3; // cycles a device dawdles before taking a byte
  logic [7:0] taken; // last byte a device took
  // byte goes on the cable first, then ready rises and is held two cycles
  task automatic present(input int i, input logic [7:0] b);
    in_data[i*8+:8] = b;
    @(posedge sys_clk);
    #1 in_ready[i] = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 in_ready[i] = 1'b0;
  endtask
  // output side: take the byte, then a two-cycle accepted pulse
  initial begin
    in_data = '0;
    in_ready = '0;
    out_accepted = '0;
    forever begin
      @(posedge sys_clk);
      for (int j = 0; j < N_OUT; j++) begin
        if (out_ready[j] === 1'b1) begin
          repeat (accept_delay) @(posedge sys_clk);
          taken = out_data[j*8+:8];
          #1 out_accepted[j] = 1'b1;
          repeat (2) @(posedge sys_clk);
          #1 out_accepted[j] = 1'b0;
          // no second pulse until the ready line has dropped
          for (int k = 0; k < 20 && out_ready[j]; k++) @(posedge sys_clk);
        end
      end
    end
  end
endmodule // pio_device_model

/* File: tb/parallel_io_handshake_ports_bench.sv */
// testbench: parallel i/o ports against a queue-based model
module parallel_io_handshake_ports_bench;
  import pio_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, arst_n, io_rready, io_rvalid, irq_n;
  io_op_t io_op;
  logic [ADDR_W-1:0] io_addr;
  logic [DATA_W-1:0] io_wdata, io_rdata, seed;
  logic [VEC_W-1:0] irq_vector;
  logic [N_IN*DATA_W-1:0] in_data;
  logic [N_IN-1:0] in_ready;
  logic [N_OUT*DATA_W-1:0] out_data, snap;
  logic [N_OUT-1:0] out_ready, out_accepted;
  int fails, cmp_count, k, v;
  logic [7:0] exp_q[$]; // bytes the read port owes us
  bit flag[N_IN]; // model of the request flags
  logic [7:0] dat[N_IN]; // bytes last presented
  pio_ports dut(.sys_clk(sys_clk), .arst_n(arst_n), .io_op(io_op), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rready(io_rready), .io_rvalid(io_rvalid), .io_rdata(io_rdata),
    .irq_n(irq_n), .irq_vector(irq_vector), .in_data(in_data), .in_ready(in_ready),
    .out_data(out_data), .out_ready(out_ready), .out_accepted(out_accepted));
  pio_device_model dev(.sys_clk(sys_clk), .out_data(out_data), .out_ready(out_ready),
    .in_data(in_data), .in_ready(in_ready), .out_accepted(out_accepted));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic int lowest();
    for (int i = 0; i < N_IN; i++) if (flag[i]) return i;
    return 0;
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // a wait that ran out counts as a mismatch and ends the run
  task automatic limit();
    if (k >= 40) begin
      chk(1, 0);
      tally_and_finish();
    end
  endtask
  // processor cycle held n clocks; caller is just past an edge
  task automatic cyc(input io_op_t op, input logic [4:0] a, input logic [7:0] d, input int n);
    io_op = op;
    io_addr = a;
    io_wdata = d;
    tick(n);
    io_op = IO_IDLE;
  endtask
  // every byte leaving the read port is checked against the queue
  always @(posedge sys_clk) begin
    if (io_rvalid === 1'b1 && io_rready) begin
      if (exp_q.size() == 0) chk(1, 0);
      else chk(io_rdata, exp_q.pop_front());
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {arst_n, io_addr, io_wdata, fails, cmp_count} = '0;
    io_op = IO_IDLE;
    io_rready = 1'b1;
    seed = 8'h32;
    repeat (5) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    chk({irq_n, irq_vector, io_rvalid, out_ready, out_data}, {1'b1, 58'h0});
    // two devices raise ready; lower index is served first
    for (int i = 3; i > 0; i -= 2) begin
      seed = lfsr(seed);
      dat[i] = seed;
      dev.present(i, seed);
      flag[i] = 1'b1;
    end
    for (k = 0; k < 40 && irq_n !== 1'b0; k++) tick(1);
    limit();
    tick(10);
    for (int n = 0; n < 2; n++) begin
      v = lowest();
      chk({irq_n, irq_vector}, {1'b0, v[2:0]});
      exp_q.push_back(dat[v]);
      cyc(IO_READ, IN_BASE + v[4:0], 8'h00, 1);
      flag[v] = 1'b0;
      tick(4);
    end
    chk(irq_n, 1'b1);
    // plain reads with no flag, back to back while the processor stalls
    seed = lfsr(seed);
    dev.in_data[16+:8] = seed;
    tick(4);
    io_rready = 1'b0;
    repeat (4) exp_q.push_back(seed);
    cyc(IO_READ, IN_BASE + 5'h02, 8'h00, 4);
    tick(6);
    chk({io_rvalid, irq_n}, 2'h3);
    io_rready = 1'b1;
    tick(10);
    chk(exp_q.size(), 0);
    cyc(IO_READ, 5'h05, 8'h00, 1);
    tick(5);
    chk(io_rvalid, 1'b0);
    // every output line, long strobes on odd ones, a slow device last
    for (int j = 0; j < N_OUT; j++) begin
      seed = lfsr(seed);
      dev.accept_delay = (j == N_OUT - 1) ? 8 : 3;
      cyc(IO_WRITE, OUT_BASE + j[4:0], seed, 1 + (j % 2) * 2);
      chk(out_ready, 6'h00);
      for (k = 0; k < 40 && out_ready[j] !== 1'b1; k++) tick(1);
      limit();
      chk({out_ready, out_data[j*8+:8]}, {6'h01 << j, seed});
      for (k = 0; k < 40 && out_ready[j] === 1'b1; k++) begin
        chk(out_data[j*8+:8], seed);
        tick(1);
      end
      limit();
      chk({out_ready, dev.taken}, {6'h00, seed});
    end
    snap = out_data;
    cyc(IO_WRITE, 5'h1F, 8'hA5, 1);
    tick(4);
    chk({out_ready, out_data}, {6'h00, snap});
    tally_and_finish();
  end
endmodule // parallel_io_handshake_ports_bench
